// *** hw/hpd_pkg.sv ***
// Constants of the hub port-disable and power configuration bank
package hpd_pkg;
   // ----------------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_OFF_SP = 8'h0a;
   localparam logic [7:0] ADDR_PORT_OFF_BP = 8'h0b;
   localparam logic [7:0] ADDR_MAX_DRAW_SP = 8'h0c;
   localparam logic [7:0] ADDR_MAX_DRAW_BP = 8'h0d;

   // ----------------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------------
   localparam logic [7:0] RST_PORT_OFF_SP = 8'h00;
   localparam logic [7:0] RST_PORT_OFF_BP = 8'h00;
   localparam logic [7:0] RST_MAX_DRAW_SP = 8'h00;
   localparam logic [7:0] RST_MAX_DRAW_BP = 8'h32;

   // ----------------------------------------------------------------------
   // Field layout
   // ----------------------------------------------------------------------
   localparam int PORT_FIRST_BIT = 1;
   localparam int DRAW_UNIT_SHIFT = 1;
   localparam int NUM_PORTS = 2;
   localparam int DRAW_MA_W = 9;
endpackage

// *** hw/hpd_map_if.sv ***
// Carrier between the register bank and the port renumbering logic
`timescale 1ns/100ps
interface hpd_map_if #(
   parameter int NPORT = 2,
   parameter int IDXW = 2
);
   logic [NPORT-1:0] off_mask;
   logic [IDXW-1:0] count;
   logic [NPORT*IDXW-1:0] phys_of_log;

   modport bank (output off_mask, input count, input phys_of_log);
   modport mapper (input off_mask, output count, output phys_of_log);
endinterface

// *** hw/hpd_port_mapper.sv ***
// Counts enabled ports and packs them into consecutive logical numbers
`timescale 1ns/100ps
module hpd_port_mapper #(
   parameter int NPORT = 2,
   parameter int IDXW = 2
) (
   hpd_map_if.mapper map
);
   // ----------------------------------------------------------------------
   // Renumbering
   // ----------------------------------------------------------------------
   if (NPORT < 1 || (1 << IDXW) <= NPORT) begin : g_bad_idxw
      $error("hpd_port_mapper: IDXW too narrow for NPORT");
   end

   // Logical port k (1 based) lands on the k-th enabled physical port;
   // entries past the count read zero, meaning no physical port.
   always_comb begin
      logic [IDXW-1:0] n;
      n = '0;
      map.phys_of_log = '0;
      for (int p = 0; p < NPORT; p++) begin
         if (!map.off_mask[p]) begin
            map.phys_of_log[n*IDXW +: IDXW] = IDXW'(p + 1); // R4
            n = n + IDXW'(1);
         end
      end
      map.count = n; // R4
   end
endmodule

// *** hw/hpd_top.sv ***
// Port-disable and max-power configuration bank of a two-port hub
// Operation
// R1 - Bits 1 and 2 govern ports; rest reserved
// R2 - Zero leaves port usable, one disables it
// R3 - Standard mode: flagged ports stay permanently disabled
// R4 - Report enabled count and renumber active ports
// R5 - Separate disable byte for bus-powered operation
// R6 - Internal default: straps choose disabled ports
// R7 - Self-powered draw byte counts 2 mA units
// R8 - Bus-powered draw byte counts 2 mA units
// R9 - Bus-powered draw byte resets to 50
// R10 - Programmer keeps self-powered draw within 100 mA
// R11 - Compound device: draw includes embedded peripheral
// R12 - Renumber select bit: zero standard, one remap; code clears all disable flags when one
// R13 - Power mode picks self or bus set
`timescale 1ns/100ps
module hpd_top #(
   parameter int NPORT = hpd_pkg::NUM_PORTS,
   parameter int IDXW = 2
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic cfg_wr_i,
   input wire logic cfg_rd_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic use_default_i,
   input wire logic port_renumber_select_bit_i,
   input wire logic self_powered_i,
   input wire logic [NPORT:1] port_off_strap_pos_i,
   input wire logic [NPORT:1] port_off_strap_neg_i,
   output logic [7:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   output logic [NPORT:1] port_off_o,
   output logic [IDXW-1:0] port_count_o,
   output logic [NPORT*IDXW-1:0] phys_of_log_o,
   output logic [7:0] max_draw_o,
   output logic [hpd_pkg::DRAW_MA_W-1:0] max_draw_ma_o,
   output logic self_powered_o
);
   if (NPORT + hpd_pkg::PORT_FIRST_BIT > 8) begin : g_bad_nport
      $error("hpd_top: port bits do not fit the byte");
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   // Straps and the power-source level come from pins.
   logic [2*NPORT:0] sync1_q, sync2_q;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= {self_powered_i, port_off_strap_neg_i,
                     port_off_strap_pos_i};
         sync2_q <= sync1_q;
      end
   end

   logic [NPORT:1] strap_pos, strap_neg;
   logic self_pwr;
   assign strap_pos = sync2_q[NPORT-1:0];
   assign strap_neg = sync2_q[2*NPORT-1:NPORT];
   assign self_pwr = sync2_q[2*NPORT];

   // ----------------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------------
   logic [7:0] off_sp_q, off_sp_d;
   logic [7:0] off_bp_q, off_bp_d;
   logic [7:0] draw_sp_q, draw_sp_d;
   logic [7:0] draw_bp_q, draw_bp_d;
   logic [7:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;

   always_comb begin
      off_sp_d = off_sp_q;
      off_bp_d = off_bp_q;
      draw_sp_d = draw_sp_q;
      draw_bp_d = draw_bp_q;
      if (cfg_wr_i) begin
         case (cfg_addr_i)
            hpd_pkg::ADDR_PORT_OFF_SP: off_sp_d = cfg_wdata_i;
            hpd_pkg::ADDR_PORT_OFF_BP: off_bp_d = cfg_wdata_i; // R5
            hpd_pkg::ADDR_MAX_DRAW_SP: draw_sp_d = cfg_wdata_i;
            hpd_pkg::ADDR_MAX_DRAW_BP: draw_bp_d = cfg_wdata_i;
            default: ;
         endcase
      end
      rvalid_d = cfg_rd_i;
      rdata_d = rdata_q;
      if (cfg_rd_i) begin
         case (cfg_addr_i)
            hpd_pkg::ADDR_PORT_OFF_SP: rdata_d = off_sp_q;
            hpd_pkg::ADDR_PORT_OFF_BP: rdata_d = off_bp_q;
            hpd_pkg::ADDR_MAX_DRAW_SP: rdata_d = draw_sp_q;
            hpd_pkg::ADDR_MAX_DRAW_BP: rdata_d = draw_bp_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         off_sp_q <= hpd_pkg::RST_PORT_OFF_SP;
         off_bp_q <= hpd_pkg::RST_PORT_OFF_BP;
         draw_sp_q <= hpd_pkg::RST_MAX_DRAW_SP;
         draw_bp_q <= hpd_pkg::RST_MAX_DRAW_BP; // R9
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
      end else begin
         off_sp_q <= off_sp_d;
         off_bp_q <= off_bp_d;
         draw_sp_q <= draw_sp_d;
         draw_bp_q <= draw_bp_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // ----------------------------------------------------------------------
   // Active disable mask
   // ----------------------------------------------------------------------
   // Only the port bits are picked out; reserved bits are stored but inert.
   function automatic logic [NPORT:1] port_bits(input logic [7:0] r);
      port_bits = r[hpd_pkg::PORT_FIRST_BIT +: NPORT]; // R1
   endfunction

   logic [NPORT:1] off_mask;

   always_comb begin
      if (port_renumber_select_bit_i) begin
         off_mask = '0; // R12
      end else if (use_default_i) begin
         // Both strap lines pulled high marks the port as disabled
         off_mask = strap_pos & strap_neg; // R6
      end else if (self_pwr) begin
         off_mask = port_bits(off_sp_q); // R13
      end else begin
         off_mask = port_bits(off_bp_q); // R13
      end
   end

   hpd_map_if #(.NPORT(NPORT), .IDXW(IDXW)) map ();
   assign map.off_mask = off_mask; // R2

   hpd_port_mapper #(.NPORT(NPORT), .IDXW(IDXW)) u_mapper (
      .map(map.mapper)
   );

   // ----------------------------------------------------------------------
   // Reported state
   // ----------------------------------------------------------------------
   function automatic logic [hpd_pkg::DRAW_MA_W-1:0] to_ma(
      input logic [7:0] b);
      to_ma = {1'b0, b} << hpd_pkg::DRAW_UNIT_SHIFT;
   endfunction

   // Map with every port enabled, so the reset map agrees with the count
   function automatic logic [NPORT*IDXW-1:0] ident_map(input int np);
      ident_map = '0;
      for (int k = 0; k < np; k++) begin
         ident_map[k*IDXW +: IDXW] = IDXW'(k + 1);
      end
   endfunction

   localparam logic [NPORT*IDXW-1:0] MAP_IDENT = ident_map(NPORT);

   logic [NPORT:1] port_off_d;
   logic [IDXW-1:0] count_d;
   logic [NPORT*IDXW-1:0] map_d;
   logic [7:0] draw_d;
   logic [hpd_pkg::DRAW_MA_W-1:0] draw_ma_d;

   always_comb begin
      port_off_d = off_mask; // R3
      count_d = map.count; // R4
      map_d = map.phys_of_log;
      // Draw figure follows the power mode the hub currently runs in
      draw_d = self_pwr ? draw_sp_q : draw_bp_q; // R13
      draw_ma_d = self_pwr ? to_ma(draw_sp_q) : to_ma(draw_bp_q); // R7 R8
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         port_off_o <= '0;
         port_count_o <= IDXW'(NPORT);
         phys_of_log_o <= MAP_IDENT; // R4
         max_draw_o <= 8'h00;
         max_draw_ma_o <= '0;
         self_powered_o <= 1'b0;
      end else begin
         port_off_o <= port_off_d;
         port_count_o <= count_d;
         phys_of_log_o <= map_d;
         max_draw_o <= draw_d;
         max_draw_ma_o <= draw_ma_d;
         self_powered_o <= self_pwr;
      end
   end

   assign cfg_rdata_o = rdata_q;
   assign cfg_rvalid_o = rvalid_q;
endmodule

// *** bench/hpd_top_assertions.sv ***
// Port-level checks of the port-disable and max-draw bank
`timescale 1ns/100ps
module hpd_top_assertions #(
   parameter int NPORT = 2,
   parameter int IDXW = 2
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic cfg_wr_i,
   input wire logic [7:0] cfg_addr_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic use_default_i,
   input wire logic port_renumber_select_bit_i,
   input wire logic [NPORT:1] port_off_strap_pos_i,
   input wire logic [NPORT:1] port_off_strap_neg_i,
   input wire logic [NPORT:1] port_off_o,
   input wire logic [IDXW-1:0] port_count_o,
   input wire logic [NPORT*IDXW-1:0] phys_of_log_o,
   input wire logic [7:0] max_draw_o,
   input wire logic [hpd_pkg::DRAW_MA_W-1:0] max_draw_ma_o,
   input wire logic self_powered_o
);
   localparam logic [3:0] MAP_TBL [4] = '{4'h9, 4'h2, 4'h1, 4'h0};
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);
   // Lone write, power mode steady, no second write behind it
   sequence s_wr(a, p);
      cfg_wr_i && cfg_addr_i == a && self_powered_o == p
      ##1 !cfg_wr_i && self_powered_o == p;
   endsequence
   a_sp_draw_write:
   assert property (s_wr(hpd_pkg::ADDR_MAX_DRAW_SP, 1'b1)
      |=> max_draw_o == $past(cfg_wdata_i, 2))
      else $error("self-powered draw byte not applied");
   a_bp_draw_write:
   assert property (s_wr(hpd_pkg::ADDR_MAX_DRAW_BP, 1'b0)
      |=> max_draw_o == $past(cfg_wdata_i, 2))
      else $error("bus-powered draw byte not applied");
   a_sp_port_write:
   assert property (s_wr(hpd_pkg::ADDR_PORT_OFF_SP, 1'b1)
      ##0 (!use_default_i && !port_renumber_select_bit_i)
      |=> port_off_o == $past(cfg_wdata_i[2:1], 2))
      else $error("port disable mask not applied");
   a_draw_in_ma:
   assert property (max_draw_ma_o == {max_draw_o, 1'b0})
      else $error("draw current not twice the byte");
   a_remap_clears:
   assert property ($past(port_renumber_select_bit_i) |-> port_off_o == '0)
      else $error("remap mode left a port disabled");
   a_strap_default:
   assert property ($past(use_default_i) && !$past(port_renumber_select_bit_i)
      |-> port_off_o == ($past(port_off_strap_pos_i, 3)
      & $past(port_off_strap_neg_i, 3)))
      else $error("straps did not decide disabled ports");
   a_count_enabled:
   assert property (port_count_o == IDXW'(NPORT - $countones(port_off_o)))
      else $error("enabled port count wrong");
   a_map_packed:
   assert property (phys_of_log_o == MAP_TBL[port_off_o])
      else $error("logical to physical map wrong");
endmodule

// *** bench/hpd_cfg_master.sv ***
// Configuration master model driving the register port
`timescale 1ns/100ps
module hpd_cfg_master (
   input wire logic core_clk_i,
   input wire logic [7:0] cfg_rdata_i,
   input wire logic cfg_rvalid_i,
   output logic cfg_wr_o = 1'b0,
   output logic cfg_rd_o = 1'b0,
   output logic [7:0] cfg_addr_o = 8'h00,
   output logic [7:0] cfg_wdata_o = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      cfg_wr_o <= 1'b1;
      cfg_addr_o <= a;
      cfg_wdata_o <= d;
      @(posedge core_clk_i);
      cfg_wr_o <= 1'b0;
      // Stale data must not look valid
      cfg_wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d,
                     output logic v);
      @(posedge core_clk_i);
      cfg_rd_o <= 1'b1;
      cfg_addr_o <= a;
      @(posedge core_clk_i);
      cfg_rd_o <= 1'b0;
      #1;
      d = cfg_rdata_i;
      v = cfg_rvalid_i;
   endtask
endmodule

// *** bench/hpd_top_tb.sv ***
// Self-checking bench of the port-disable and max-draw bank
`timescale 1ns/100ps
module hpd_top_tb;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cfg_wr_i, cfg_rd_i, cfg_rvalid_o, self_powered_o, rd_ok;
   logic use_default_i = 1'b0;
   logic port_renumber_select_bit_i = 1'b0;
   logic self_powered_i = 1'b0;
   logic [2:1] port_off_strap_pos_i = 2'b00;
   logic [2:1] port_off_strap_neg_i = 2'b00;
   logic [2:1] port_off_o;
   logic [1:0] port_count_o;
   logic [3:0] phys_of_log_o;
   logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, max_draw_o, rd_v;
   logic [8:0] max_draw_ma_o;
   int num_errors = 0;
   int comparisons = 0;
   localparam logic [3:0] MAP_TBL [4] = '{4'h9, 4'h2, 4'h1, 4'h0};
   logic [7:0] offs [5] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'hf9};
   always #12.5 core_clk_i = ~core_clk_i;
   hpd_top u_hpd_top (.core_clk_i, .nrst_i, .cfg_wr_i, .cfg_rd_i,
      .cfg_addr_i, .cfg_wdata_i, .use_default_i, .port_renumber_select_bit_i,
      .self_powered_i, .port_off_strap_pos_i, .port_off_strap_neg_i,
      .cfg_rdata_o, .cfg_rvalid_o, .port_off_o, .port_count_o,
      .phys_of_log_o, .max_draw_o, .max_draw_ma_o, .self_powered_o);
   hpd_cfg_master u_hpd_cfg_master (.core_clk_i, .cfg_rdata_i(cfg_rdata_o),
      .cfg_rvalid_i(cfg_rvalid_o), .cfg_wr_o(cfg_wr_i), .cfg_rd_o(cfg_rd_i),
      .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i));
   task automatic chk(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      u_hpd_cfg_master.rd(a, rd_v, rd_ok);
      chk(rd_ok, 1'b1);
      chk(rd_v, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic report_and_stop;
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Whole run is some 90 cycles; this leaves wide margin
   initial begin
      #20000;
      num_errors++;
      report_and_stop;
   end
   initial begin
      repeat (4) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      settle(2);
      rchk(hpd_pkg::ADDR_PORT_OFF_SP, hpd_pkg::RST_PORT_OFF_SP);
      rchk(hpd_pkg::ADDR_PORT_OFF_BP, hpd_pkg::RST_PORT_OFF_BP);
      rchk(hpd_pkg::ADDR_MAX_DRAW_SP, hpd_pkg::RST_MAX_DRAW_SP);
      rchk(hpd_pkg::ADDR_MAX_DRAW_BP, 8'h32);
      rchk(8'h0e, 8'h00);
      chk(max_draw_ma_o, 9'd100);
      $display("test reset done");
      @(posedge core_clk_i) self_powered_i <= 1'b1;
      settle(4);
      u_hpd_cfg_master.wr(hpd_pkg::ADDR_MAX_DRAW_SP, 8'h2f);
      settle(2);
      chk(max_draw_ma_o, 9'd94);
      chk(max_draw_o, 8'h2f);
      chk(self_powered_o, 1'b1);
      for (int i = 0; i < 5; i++) begin
         u_hpd_cfg_master.wr(hpd_pkg::ADDR_PORT_OFF_SP, offs[i]);
         settle(2);
         chk(port_off_o, offs[i][2:1]);
         chk(port_count_o, 2'd2 - (offs[i][2] + offs[i][1]));
         chk(phys_of_log_o, MAP_TBL[offs[i][2:1]]);
         rchk(hpd_pkg::ADDR_PORT_OFF_SP, offs[i]);
      end
      $display("test self powered done");
      u_hpd_cfg_master.wr(hpd_pkg::ADDR_PORT_OFF_BP, 8'h04);
      u_hpd_cfg_master.wr(hpd_pkg::ADDR_MAX_DRAW_BP, 8'h10);
      settle(2);
      chk(port_off_o, 2'b00);
      @(posedge core_clk_i) self_powered_i <= 1'b0;
      settle(5);
      chk(port_off_o, 2'b10);
      chk(max_draw_ma_o, 9'h020);
      chk(max_draw_o, 8'h10);
      chk(self_powered_o, 1'b0);
      u_hpd_cfg_master.wr(hpd_pkg::ADDR_MAX_DRAW_BP, 8'h19);
      settle(2);
      chk(max_draw_o, 8'h19);
      chk(max_draw_ma_o, 9'd50);
      $display("test bus powered done");
      @(posedge core_clk_i) port_renumber_select_bit_i <= 1'b1;
      settle(2);
      chk(port_count_o, 2'd2);
      @(posedge core_clk_i) port_renumber_select_bit_i <= 1'b0;
      settle(2);
      chk(port_off_o, 2'b10);
      $display("test remap done");
      @(posedge core_clk_i) port_off_strap_pos_i <= 2'b11;
      @(posedge core_clk_i) port_off_strap_neg_i <= 2'b01;
      settle(4);
      @(posedge core_clk_i) use_default_i <= 1'b1;
      settle(2);
      chk(port_off_o, 2'b01);
      $display("test defaults done");
      report_and_stop;
   end
endmodule
bind hpd_top hpd_top_assertions #(.NPORT(NPORT), .IDXW(IDXW))
   u_hpd_top_assertions (.core_clk_i, .nrst_i, .cfg_wr_i, .cfg_addr_i,
   .cfg_wdata_i, .use_default_i, .port_renumber_select_bit_i,
   .port_off_strap_pos_i, .port_off_strap_neg_i, .port_off_o, .port_count_o,
   .phys_of_log_o, .max_draw_o, .max_draw_ma_o, .self_powered_o);
